// ===== verilog/mcr_map.svh
// Register map and field constants of the channel control bank
//------------------------------------------------------------
// Overview of operation
// [RULE1] Software keeps test select at zero normally
// [RULE2] Loopback off or AIS bit clear: normal
// [RULE3] Loopback on with AIS bit: send AIS
// [RULE4] Channel reset bit device_soft_reset that channel
// [RULE5] Channel reset bits stay until written zero
// [RULE6] Device reset bit device_soft_reset all, self clears
// [RULE7] Any reset sets channel config to ones
// [RULE8] Address high digit selects the channel
// [RULE9] Format code 01 STS-3, 11 STM-1
// [RULE10] Software programs same format in all channels
// [RULE11] Drop position field picks dropped tributary
// [RULE12] Same drop tributary allowed for many channels
// [RULE13] Unused channel still gets a drop position
// [RULE14] Add position field picks added tributary
// [RULE15] Shared add position raises contention alarm; the code raises none when the shared position is code 11
// [RULE16] Software gives each channel distinct add position
// [RULE17] Line mode bit: zero E3, one DS3
// [RULE18] Software writes zero to reserved bits
// [RULE19] Line loopback feeds receive into transmit
//------------------------------------------------------------
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH
`define MCR_TLA_ADDR 12'h0c5
`define MCR_SRST_ADDR 12'h0c7
`define MCR_CFG_LOW 8'hc0
`define MCR_CFG_RST 8'hff
`define MCR_ZERO8 8'h00
`define MCR_AIS_BIT 0
`define MCR_DEVRST_BIT 0
`define MCR_FMT_STS3 2'h1
`define MCR_FMT_STM1 2'h3
`define MCR_POS_NONE 2'h3
// Address fields: channel digit and register byte
`define MCR_CH_HI 11
`define MCR_CH_LO 8
`define MCR_REG_HI 7
// Field positions inside the common and channel registers
`define MCR_TLA_HI 2
`define MCR_TEST_HI 2
`define MCR_TEST_LO 1
`define MCR_CHRST_HI 3
`define MCR_CHRST_LO 1
`define MCR_FMT_HI 7
`define MCR_FMT_LO 6
`define MCR_DROP_HI 5
`define MCR_DROP_LO 4
`define MCR_ADD_HI 3
`define MCR_ADD_LO 2
`define MCR_MODE_BIT 0
`endif

// ===== verilog/mcr_pkg.sv
// Types shared by the channel control bank
`default_nettype none
package mcr_pkg;
  typedef logic [7:0] mcr_byte_t;
  typedef logic [1:0] mcr_pos_t;
  // Device soft reset sequencing
  typedef enum logic {MCR_ST_RUN, MCR_ST_DEVRST} mcr_state_t;
endpackage
`default_nettype wire

// ===== verilog/mcr_channel_regs.sv
// Channel control register bank of the three channel mapper
`include "mcr_map.svh"
`default_nettype none
module mcr_channel_regs (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] line_loopback_enable_i,
  output logic [7:0] rdata_o,
  output logic [1:0] test_select_o,
  output logic [2:0] channel_reset_o,
  output logic [5:0] bus_format_o,
  output logic [2:0] sts3_mode_o,
  output logic [2:0] stm1_mode_o,
  output logic [5:0] drop_position_o,
  output logic [5:0] add_position_o,
  output logic [2:0] ds3_mode_o,
  output logic [2:0] line_loop_active_o,
  output logic [2:0] ais_insert_o,
  output logic add_bus_contention_alarm_o
);

  //----------------------------------------------------------
  // Address decode
  //----------------------------------------------------------
  logic hit_tla;
  logic hit_srst;
  logic [2:0] hit_cfg;

  assign hit_tla = (addr_i == `MCR_TLA_ADDR);
  assign hit_srst = (addr_i == `MCR_SRST_ADDR);

  // Leading digit picks the channel, low byte the register
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hit_cfg[i] = (addr_i[`MCR_REG_HI:0] == `MCR_CFG_LOW) &&
                   (addr_i[`MCR_CH_HI:`MCR_CH_LO] == 4'(i + 1)); // RULE8
    end
  end

  //----------------------------------------------------------
  // Control state
  //----------------------------------------------------------
  mcr_pkg::mcr_state_t state_q;
  mcr_pkg::mcr_state_t state_d;
  logic [2:0] tla_q;
  logic [2:0] tla_d;
  logic [2:0] chrst_q;
  logic [2:0] chrst_d;
  mcr_pkg::mcr_byte_t cfg_q [3];
  mcr_pkg::mcr_byte_t cfg_d [3];
  logic run;

  assign run = (state_q == mcr_pkg::MCR_ST_RUN);

  // Writes are dropped during the soft reset cycle itself
  always_comb begin
    state_d = state_q;
    tla_d = tla_q;
    chrst_d = chrst_q;
    cfg_d = cfg_q;
    unique case (state_q)
      mcr_pkg::MCR_ST_DEVRST: begin
        // Same end state as the reset pin, then back to run
        state_d = mcr_pkg::MCR_ST_RUN; // RULE6
        tla_d = '0;
        chrst_d = '0;
        for (int i = 0; i < 3; i++) begin
          cfg_d[i] = `MCR_CFG_RST; // RULE7
        end
      end
      mcr_pkg::MCR_ST_RUN: begin
        if (wr_i && hit_tla) begin
          tla_d = wdata_i[`MCR_TLA_HI:0];
        end
        if (wr_i && hit_srst) begin
          chrst_d = wdata_i[`MCR_CHRST_HI:`MCR_CHRST_LO]; // RULE5
          if (wdata_i[`MCR_DEVRST_BIT]) begin
            state_d = mcr_pkg::MCR_ST_DEVRST; // RULE6
          end
        end
        for (int i = 0; i < 3; i++) begin
          // A held channel reset overrides any config write
          if (chrst_q[i]) begin
            cfg_d[i] = `MCR_CFG_RST; // RULE4
          end else if (wr_i && hit_cfg[i]) begin
            cfg_d[i] = wdata_i; // RULE8
          end
        end
      end
    endcase
  end

  // Register control state
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= mcr_pkg::MCR_ST_RUN;
      tla_q <= '0;
      chrst_q <= '0;
      for (int i = 0; i < 3; i++) begin
        cfg_q[i] <= `MCR_CFG_RST; // RULE7
      end
    end else begin
      state_q <= state_d;
      tla_q <= tla_d;
      chrst_q <= chrst_d;
      cfg_q <= cfg_d;
    end
  end

  //----------------------------------------------------------
  // Read path
  //----------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Data is held until the next read; unmapped reads give zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_i) begin
      rdata_d = `MCR_ZERO8;
      if (hit_tla) begin
        rdata_d = {5'h00, tla_q};
      end
      if (hit_srst) begin
        rdata_d = {4'h0, chrst_q, !run};
      end
      for (int i = 0; i < 3; i++) begin
        if (hit_cfg[i]) begin
          rdata_d = cfg_q[i];
        end
      end
    end
  end

  // Register read data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= `MCR_ZERO8;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  //----------------------------------------------------------
  // Decoded controls toward the datapath
  //----------------------------------------------------------
  logic [1:0] tst_q;
  logic [1:0] tst_d;
  logic [2:0] crst_q;
  logic [2:0] crst_d;
  logic [5:0] fmt_q;
  logic [5:0] fmt_d;
  logic [2:0] sts3_q;
  logic [2:0] sts3_d;
  logic [2:0] stm1_q;
  logic [2:0] stm1_d;
  logic [5:0] drop_q;
  logic [5:0] drop_d;
  logic [5:0] add_q;
  logic [5:0] add_d;
  logic [2:0] ds3_q;
  logic [2:0] ds3_d;
  logic [2:0] loop_q;
  logic [2:0] loop_d;
  logic [2:0] ais_q;
  logic [2:0] ais_d;
  logic cont_q;
  logic cont_d;
  mcr_pkg::mcr_pos_t apos [3];

  // One cycle of latency keeps every output on a flip-flop
  always_comb begin
    tst_d = tla_q[`MCR_TEST_HI:`MCR_TEST_LO];
    crst_d = chrst_q | {3{!run}};
    cont_d = 1'b0;
    for (int i = 0; i < 3; i++) begin
      apos[i] = cfg_q[i][`MCR_ADD_HI:`MCR_ADD_LO];
      fmt_d[2*i +: 2] = cfg_q[i][`MCR_FMT_HI:`MCR_FMT_LO];
      // Reserved format codes enable neither mapping
      sts3_d[i] = (cfg_q[i][`MCR_FMT_HI:`MCR_FMT_LO] ==
                   `MCR_FMT_STS3); // RULE9
      stm1_d[i] = (cfg_q[i][`MCR_FMT_HI:`MCR_FMT_LO] ==
                   `MCR_FMT_STM1); // RULE9
      // No exclusion: channels may share a drop tributary
      drop_d[2*i +: 2] = cfg_q[i][`MCR_DROP_HI:`MCR_DROP_LO]; // RULE11 RULE12
      add_d[2*i +: 2] = cfg_q[i][`MCR_ADD_HI:`MCR_ADD_LO]; // RULE14
      ds3_d[i] = cfg_q[i][`MCR_MODE_BIT]; // RULE17
      loop_d[i] = line_loopback_enable_i[i]; // RULE19
      // AIS only replaces data while the loop is closed
      ais_d[i] = line_loopback_enable_i[i] &&
                 tla_q[`MCR_AIS_BIT]; // RULE2 RULE3
    end
    // Unused code 11 is the parking place, not a clash
    for (int i = 0; i < 2; i++) begin
      for (int j = i + 1; j < 3; j++) begin
        if (apos[i] == apos[j] && apos[i] != `MCR_POS_NONE) begin
          cont_d = 1'b1; // RULE15
        end
      end
    end
  end

  // Register decoded controls
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tst_q <= '0;
      crst_q <= '1;
      fmt_q <= '1;
      sts3_q <= '0;
      stm1_q <= '1;
      drop_q <= '1;
      add_q <= '1;
      ds3_q <= '1;
      loop_q <= '0;
      ais_q <= '0;
      cont_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      crst_q <= crst_d;
      fmt_q <= fmt_d;
      sts3_q <= sts3_d;
      stm1_q <= stm1_d;
      drop_q <= drop_d;
      add_q <= add_d;
      ds3_q <= ds3_d;
      loop_q <= loop_d;
      ais_q <= ais_d;
      cont_q <= cont_d;
    end
  end

  assign test_select_o = tst_q;
  assign channel_reset_o = crst_q;
  assign bus_format_o = fmt_q;
  assign sts3_mode_o = sts3_q;
  assign stm1_mode_o = stm1_q;
  assign drop_position_o = drop_q;
  assign add_position_o = add_q;
  assign ds3_mode_o = ds3_q;
  assign line_loop_active_o = loop_q;
  assign ais_insert_o = ais_q;
  assign add_bus_contention_alarm_o = cont_q;

  //----------------------------------------------------------
  // Assertions
  //----------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_ais_needs_loop: // RULE2
    assert property (!line_loopback_enable_i[0] |=> !ais_insert_o[0])
    else $error("AIS asserted without loopback");

  a_ais_on_loop: // RULE3
    assert property (line_loopback_enable_i[1] && tla_q[`MCR_AIS_BIT]
                     |=> ais_insert_o[1] && line_loop_active_o[1])
    else $error("AIS missing under loopback");

  a_chan_rst_hold: // RULE4
    assert property (run && chrst_q[1] |=> cfg_q[1] == `MCR_CFG_RST
                     && channel_reset_o[1])
    else $error("Channel reset did not hold config");

  a_chan_rst_sticky: // RULE5
    assert property (run && !(wr_i && hit_srst)
                     |=> chrst_q == $past(chrst_q))
    else $error("Channel reset bits changed by themselves");

  a_dev_rst_entry: // RULE6
    assert property (run && wr_i && hit_srst && wdata_i[0]
                     |=> !run ##1 run)
    else $error("Device reset not a single cycle");

  a_dev_rst_ones: // RULE7
    assert property (!run |=> cfg_q[2] == `MCR_CFG_RST
                     && chrst_q == 3'h0 ##1 channel_reset_o == 3'h0)
    else $error("Soft reset left state behind");

  a_chan_select: // RULE8
    assert property (run && wr_i && hit_cfg[1] && !chrst_q[1]
                     |=> cfg_q[1] == $past(wdata_i)
                     && cfg_q[0] == $past(cfg_q[0]))
    else $error("Config write reached wrong channel");

  a_fmt_decode: // RULE9
    assert property (##1 stm1_mode_o[2] ==
                     ($past(cfg_q[2][7:6]) == `MCR_FMT_STM1))
    else $error("Format decode wrong");

  a_drop_follow: // RULE11
    assert property (##1 drop_position_o[3:2] == $past(cfg_q[1][5:4]))
    else $error("Drop position mismatch");

  a_add_follow: // RULE14
    assert property (##1 add_position_o[5:4] == $past(cfg_q[2][3:2]))
    else $error("Add position mismatch");

  a_add_clash: // RULE15
    assert property (cfg_q[1][3:2] == cfg_q[2][3:2]
                     && cfg_q[1][3:2] != `MCR_POS_NONE
                     |=> add_bus_contention_alarm_o)
    else $error("Add contention not flagged");

  a_line_mode: // RULE17
    assert property (##1 ds3_mode_o[0] == $past(cfg_q[0][0]))
    else $error("Line mode mismatch");

  a_loop_follow: // RULE19
    assert property (##1 line_loop_active_o == $past(line_loopback_enable_i))
    else $error("Loopback control lags");

  c_dev_reset: cover property (run && wr_i && hit_srst && wdata_i[0]);
  c_shared_drop: cover property (drop_position_o[1:0] ==
                                 drop_position_o[3:2]
                                 && drop_position_o[1:0] != 2'h3);
  c_ais_sent: cover property (ais_insert_o[2]);
  c_clash: cover property (add_bus_contention_alarm_o);

endmodule // mcr_channel_regs
`default_nettype wire

// ===== tb/mcr_host.sv
// Host processor model that drives the register bus
`default_nettype none
module mcr_host (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [11:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus starts low with no strobe
  initial begin
    addr_o = 12'h000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Reserved and test bits always go out as zero
  function automatic logic [7:0] mcr_mask(input logic [11:0] a);
    if (a == 12'h0c5) return 8'h01;
    if (a == 12'h0c7) return 8'h0f;
    return 8'hfd;
  endfunction
  // Released lines show the inverse, so stale values cannot pass
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d & mcr_mask(a);
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  // Read data is registered on the taken edge and sampled half a cycle later
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge mclk_i);
    d = rdata_i;
    rd_o = 1'b0;
    addr_o = ~addr_o;
  endtask
endmodule // mcr_host
`default_nettype wire

// ===== tb/mcr_channel_regs_tb.sv
// Self-checking bench of the channel control bank
`default_nettype none
module mcr_channel_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] loop_en = 3'h0;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic wr, rd, alarm;
  logic [1:0] tsel;
  logic [2:0] chrst, sts3, stm1, ds3, lpa, ais;
  logic [5:0] fmt, dpos, apos;
  int failures = 0;
  int cmp_count = 0;
  int n;
  mcr_channel_regs uut (.mclk_i(mclk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .line_loopback_enable_i(loop_en),
    .rdata_o(rdata), .test_select_o(tsel), .channel_reset_o(chrst),
    .bus_format_o(fmt), .sts3_mode_o(sts3), .stm1_mode_o(stm1),
    .drop_position_o(dpos), .add_position_o(apos), .ds3_mode_o(ds3),
    .line_loop_active_o(lpa), .ais_insert_o(ais),
    .add_bus_contention_alarm_o(alarm));
  mcr_host host (.mclk_i(mclk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  //----------------------------------------------------------
  // Checking and closing
  //----------------------------------------------------------
  task automatic chk(input string s, input logic [7:0] g,
                     input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //----------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------
  task automatic t_reset();
    for (int c = 1; c <= 3; c++) begin
      host.rd_reg({c[3:0], 8'hc0}, rv);
      chk("cfg", rv, 8'hff);
    end
    host.rd_reg(12'h0c7, rv);
    chk("srst", rv, 8'h00);
    chk("modes", {1'b0, stm1, ds3, alarm}, 8'h7e);
    chk("chrst", {5'h00, chrst}, 8'h00);
    $display("test reset done");
  endtask
  // Shared drop, distinct adds, then a forced add clash
  task automatic t_cfg();
    host.wr_reg(12'h1c0, 8'h41);
    host.wr_reg(12'h2c0, 8'h44);
    host.wr_reg(12'h3c0, 8'h69);
    @(negedge mclk);
    chk("fmt", {2'h0, fmt}, 8'h15);
    chk("mode", {2'h0, sts3, stm1}, 8'h38);
    chk("drop", {2'h0, dpos}, 8'h20);
    chk("add", {2'h0, apos}, 8'h24);
    chk("ds3", {5'h00, ds3}, 8'h05);
    chk("alarm", {7'h00, alarm}, 8'h00);
    host.rd_reg(12'h2c0, rv);
    chk("cfg2", rv, 8'h44);
    host.wr_reg(12'h0c6, 8'h55);
    host.rd_reg(12'h4c0, rv);
    chk("unmapped", rv, 8'h00);
    host.wr_reg(12'h1c0, 8'hc1);
    host.wr_reg(12'h2c0, 8'hc4);
    host.wr_reg(12'h3c0, 8'hc5);
    @(negedge mclk);
    chk("stm1", {5'h00, stm1}, 8'h07);
    chk("alarm", {7'h00, alarm}, 8'h01);
    $display("test config done");
  endtask
  task automatic t_loop();
    loop_en = 3'b010;
    host.wr_reg(12'h0c5, 8'h00);
    @(negedge mclk);
    chk("loop", {2'h0, lpa, ais}, 8'h10);
    host.wr_reg(12'h0c5, 8'h07);
    @(negedge mclk);
    chk("ais", {2'h0, lpa, ais}, 8'h12);
    chk("tsel", {6'h00, tsel}, 8'h00);
    loop_en = 3'b000;
    @(negedge mclk);
    chk("ais", {2'h0, lpa, ais}, 8'h00);
    $display("test loopback done");
  endtask
  // Channel reset must persist with no self clearing
  task automatic t_chrst();
    host.wr_reg(12'h0c7, 8'h04);
    @(negedge mclk);
    chk("chrst", {5'h00, chrst}, 8'h02);
    host.wr_reg(12'h2c0, 8'hc4);
    host.rd_reg(12'h2c0, rv);
    chk("cfg2", rv, 8'hff);
    repeat (20) @(negedge mclk);
    host.rd_reg(12'h0c7, rv);
    chk("srst", rv, 8'h04);
    host.wr_reg(12'h0c7, 8'h00);
    host.wr_reg(12'h2c0, 8'hc4);
    host.rd_reg(12'h2c0, rv);
    chk("cfg2", rv, 8'hc4);
    $display("test channel reset done");
  endtask
  task automatic t_devrst();
    host.wr_reg(12'h1c0, 8'hc8);
    host.wr_reg(12'h0c5, 8'h01);
    host.wr_reg(12'h0c7, 8'h01);
    for (n = 0; n < 4 && chrst !== 3'b111; n++) @(negedge mclk);
    chk("chrst", {5'h00, chrst}, 8'h07);
    repeat (2) @(negedge mclk);
    host.rd_reg(12'h0c7, rv);
    chk("srst", rv, 8'h00);
    host.rd_reg(12'h0c5, rv);
    chk("tla", rv, 8'h00);
    host.rd_reg(12'h1c0, rv);
    chk("cfg1", rv, 8'hff);
    $display("test device reset done");
  endtask
  //----------------------------------------------------------
  // Clock, sequence and watchdog
  //----------------------------------------------------------
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_cfg();
    t_loop();
    t_chrst();
    t_devrst();
    test_done();
  end
  // Tests need about a hundred cycles; 100us allows 4000, near forty times that
  initial begin
    #100us;
    failures++;
    test_done();
  end
endmodule // mcr_channel_regs_tb
`default_nettype wire
